// ### sim/testbench.sv
// Self-checking bench for the socket voltage and clock control register.
// Assumes spc_pkg and spc_socket_ctrl are compiled first; APB master on pclk.
`timescale 1ns/1ns
module testbench;
  import spc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             pclk, presetn, psel, penable, pwrite, er, ok;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, w;
  logic [3:0]       pstrb;
  logic             pready, pslverr, std_dis, force_cls, reint, idle, host;
  logic             card_clock_stop_ok, supply_refused;
  logic [2:0]       c, g;
  spc_card_class_t  card_class;
  spc_socket_out_t  socket_out, eo;
  int               bad_count, num_checks, k;

  spc_socket_ctrl spc_socket_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .std_video_model_disable(std_dis), .card_class(card_class),
    .force_class_write(force_cls), .card_reinterrogate_trigger(reint), .socket_idle(idle),
    .host_clock_stopping(host), .socket_out(socket_out), .card_clock_stop_ok(card_clock_stop_ok),
    .supply_refused(supply_refused)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task miss(input string s);
    bad_count++;
    $display("MISMATCH %0t %s", $time, s);
  endtask

  task chk_word(input logic [31:0] gv, input logic [31:0] ev, input string s);
    num_checks++;
    if (gv !== ev) miss(s);
  endtask

  task chk_bit(input logic gv, input logic ev, input string s);
    num_checks++;
    if (gv !== ev) miss(s);
  endtask

  task chk_out(input spc_socket_out_t gv, input spc_socket_out_t ev, input string s);
    num_checks++;
    if (gv !== ev) miss(s);
  endtask

  // One APB transfer; pready, read data and error are all taken at the completing rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miss("no pready");
      give_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] ev, input logic ee, input string s);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk_word(rd, ev, s);
    chk_bit(er, ee, "pslverr");
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {std_dis, force_cls, reint, idle, host} = '0;
    card_class = spc_card_class_t'(4'b1000);
    presetn = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk_out(socket_out, spc_socket_out_t'(8'h00), "reset outputs");
    rd_chk(12'h010, 32'h0000_0400, 1'b0, "reset value");
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'h1);
    rd_chk(12'h010, 32'h0000_04F7, 1'b0, "lane0 write");
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'h2);
    rd_chk(12'h010, 32'h0000_0EF7, 1'b0, "lane1 write");
    settle(2);
    chk_bit(socket_out.video_on, 1'b1, "video on");
    apb(1'b1, 12'h010, 32'h0000_0000, 4'hF);
    rd_chk(12'h010, 32'h0000_0400, 1'b0, "video off");
    @(posedge pclk);
    std_dis <= 1'b1;
    rd_chk(12'h010, 32'h0000_0000, 1'b0, "model bit");
    std_dis <= 1'b0;
    rd_chk(12'h014, 32'h0000_0000, 1'b1, "unmapped read");
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, 4'hF);
    rd_chk(12'h010, 32'h0000_0400, 1'b0, "unmapped write");
    for (k = 0; k < 16; k++) begin
      c = k[2:0];
      ok = k[3] ? (c == 3'h1 || c == 3'h2) : (c == 3'h2);
      g = ok ? c : 3'h0;
      eo = k[3] ? spc_socket_out_t'({3'h0, g, 2'b00}) : spc_socket_out_t'({g, 3'h0, 2'b00});
      w = k[3] ? {29'h0, c} : {25'h0, c, 4'h0};
      apb(1'b1, 12'h010, w, 4'hF);
      rd_chk(12'h010, w | 32'h0000_0400, 1'b0, "supply field");
      settle(2);
      chk_out(socket_out, eo, "supply grant");
      chk_bit(supply_refused, c != 3'h0 && !ok, "refused");
    end
    for (k = 0; k < 8; k++) begin
      apb(1'b1, 12'h010, k[2] ? 32'h0000_0080 : 32'h0000_0000, 4'hF);
      idle <= k[1];
      host <= k[0];
      settle(2);
      chk_bit(card_clock_stop_ok, k[1] && (k[2] || k[0]), "clock stop");
    end
    idle <= 1'b0;
    host <= 1'b0;
    apb(1'b1, 12'h010, 32'h0000_0021, 4'hF);
    settle(2);
    eo = spc_socket_out_t'({3'h2, 3'h1, 2'b00});
    chk_out(socket_out, eo, "granted");
    @(posedge pclk);
    force_cls <= 1'b1;
    @(posedge pclk);
    force_cls <= 1'b0;
    settle(3);
    chk_out(socket_out, spc_socket_out_t'(8'h00), "forced off");
    chk_bit(supply_refused, 1'b0, "forced refused");
    @(posedge pclk);
    reint <= 1'b1;
    @(posedge pclk);
    reint <= 1'b0;
    settle(4);
    chk_out(socket_out, eo, "re-enabled");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h010, 32'h0000_0400, 1'b0, "second reset");
    give_verdict();
  end
endmodule

// ### verilog/spc_pkg.sv
// Package for the socket power control register block.
// Assumes one APB clock domain; shared by the register top and the supply filter.
package spc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SPC_CTRL_OFFSET    = 12'h010;
  localparam int          SPC_ADDR_W         = 12;
  localparam logic [31:0] SPC_ZERO_WORD      = 32'h0000_0000;
  localparam logic [31:0] SPC_ERR_READ_WORD  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SPC_VIDACT_BIT  = 11;
  localparam int SPC_STDVID_BIT  = 10;
  localparam int SPC_VIDEN_BIT   = 9;
  localparam int SPC_RSV8_BIT    = 8;
  localparam int SPC_STOP_BIT    = 7;
  localparam int SPC_MAIN_LSB    = 4;
  localparam int SPC_RSV3_BIT    = 3;
  localparam int SPC_PROG_LSB    = 0;
  localparam int SPC_FIELD_W     = 3;

  // ----------------------------------------------------------------
  // Supply encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SPC_SUP_OFF   = 3'h0;
  localparam logic [2:0] SPC_SUP_12V   = 3'h1;
  localparam logic [2:0] SPC_SUP_5V    = 3'h2;
  localparam logic [2:0] SPC_SUP_3V3   = 3'h3;
  localparam logic [2:0] SPC_SUP_XV    = 3'h4;
  localparam logic [2:0] SPC_SUP_YV    = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       SPC_RST_BIT   = 1'b0;
  localparam logic [2:0] SPC_RST_FIELD = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_5v;
    logic is_3v3;
    logic is_xv;
    logic is_yv;
  } spc_card_class_t;

  typedef struct packed {
    logic [2:0] main_supply;
    logic [2:0] program_supply;
    logic       video_on;
    logic       clock_stop_allowed;
  } spc_socket_out_t;

  typedef enum logic [1:0] {
    SPC_ST_ENABLED  = 2'b00,
    SPC_ST_DISABLED = 2'b01,
    SPC_ST_REQUERY  = 2'b11
  } spc_state_t;

endpackage

// ### verilog/spc_socket_ctrl.sv
// Socket voltage and clock control register with APB slave.
// Assumes APB master on pclk; card class and force inputs synchronous to pclk.
//
// Overview of operation
// - Bits 31 to 12 read zero; writes there are ignored.
// - Bit 8 reads zero; writes to it have no effect.
// - Bit 3 reads zero.
// - Bit 11 reads back the video enable bit.
// - Bit 10 reads one while the diagnostic video model disable is clear.
// - Bit 9 is the read/write zoomed-video enable for the socket.
// - Policy zero: stop card clock only when idle and host clock stopping.
// - Policy one: stop card clock whenever the socket is idle.
// - Bits 6 to 4 hold the main supply request field.
// - Bits 2 to 0 hold the programming supply request field.
// - Only voltages accepted by the card, or 12 V on the programming supply, are applied; others refused while enabled.
// - Reset clears every bit except bit 10.
// - Forcing a card voltage class disables acting on requests.
// - Re-interrogation trigger re-enables the register after re-query.
`timescale 1ns/1ns
module spc_socket_ctrl (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [spc_pkg::SPC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         std_video_model_disable,
  input  wire spc_pkg::spc_card_class_t     card_class,
  input  wire logic                         force_class_write,
  input  wire logic                         card_reinterrogate_trigger,
  input  wire logic                         socket_idle,
  input  wire logic                         host_clock_stopping,
  output spc_pkg::spc_socket_out_t          socket_out,
  output logic                              card_clock_stop_ok,
  output logic                              supply_refused
);
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic       video_port_enable_reg;
  logic       card_clock_stop_policy_reg;
  logic [2:0] main_supply_request_reg;
  logic [2:0] program_supply_request_reg;
  spc_state_t state_reg;
  spc_state_t state_next;
  logic [2:0] main_grant;
  logic [2:0] prog_grant;
  logic       main_refused;
  logic       prog_refused;
  logic       ctrl_enabled;
  logic       wr_access;
  logic       rd_access;
  logic       hit;
  logic [31:0] read_word;

  function automatic logic addr_hit(input logic [SPC_ADDR_W-1:0] a);
    addr_hit = (a == SPC_CTRL_OFFSET);
  endfunction

  assign hit          = addr_hit(paddr);
  assign wr_access    = psel && penable && pwrite && hit;
  assign rd_access    = psel && !penable && !pwrite;
  assign ctrl_enabled = (state_reg == SPC_ST_ENABLED);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_port_enable_reg      <= SPC_RST_BIT;
      card_clock_stop_policy_reg <= SPC_RST_BIT;
      main_supply_request_reg    <= SPC_RST_FIELD;
      program_supply_request_reg <= SPC_RST_FIELD;
    end else if (wr_access) begin
      // Only bits 9, 7, 6..4 and 2..0 are stored; upper, 11, 10, 8 and 3 are dropped
      if (pstrb[1]) begin
        video_port_enable_reg <= pwdata[SPC_VIDEN_BIT];
      end
      if (pstrb[0]) begin
        card_clock_stop_policy_reg <= pwdata[SPC_STOP_BIT];
        main_supply_request_reg    <= pwdata[SPC_MAIN_LSB +: SPC_FIELD_W];
        program_supply_request_reg <= pwdata[SPC_PROG_LSB +: SPC_FIELD_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPC_ST_ENABLED: begin
        if (force_class_write) begin
          state_next = SPC_ST_DISABLED;
        end
      end
      SPC_ST_DISABLED: begin
        if (card_reinterrogate_trigger) begin
          state_next = SPC_ST_REQUERY;
        end
      end
      SPC_ST_REQUERY: begin
        if (force_class_write) begin
          state_next = SPC_ST_DISABLED;
        end else begin
          state_next = SPC_ST_ENABLED;
        end
      end
      default: state_next = SPC_ST_DISABLED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SPC_ST_ENABLED;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Supply filtering
  // ----------------------------------------------------------------
  spc_supply_filter u_main (
    .req     (main_supply_request_reg),
    .is_prog (1'b0),
    .card    (card_class),
    .enabled (ctrl_enabled),
    .grant   (main_grant),
    .refused (main_refused)
  );

  spc_supply_filter u_prog (
    .req     (program_supply_request_reg),
    .is_prog (1'b1),
    .card    (card_class),
    .enabled (ctrl_enabled),
    .grant   (prog_grant),
    .refused (prog_refused)
  );

  // ----------------------------------------------------------------
  // Socket outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      socket_out         <= '0;
      supply_refused     <= 1'b0;
      card_clock_stop_ok <= 1'b0;
    end else begin
      socket_out.main_supply        <= main_grant;
      socket_out.program_supply     <= prog_grant;
      socket_out.video_on           <= video_port_enable_reg;
      socket_out.clock_stop_allowed <= card_clock_stop_policy_reg;
      supply_refused                <= main_refused || prog_refused;
      if (card_clock_stop_policy_reg) begin
        card_clock_stop_ok <= socket_idle;
      end else begin
        card_clock_stop_ok <= socket_idle && host_clock_stopping;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and APB answer
  // ----------------------------------------------------------------
  always_comb begin
    read_word                                       = SPC_ZERO_WORD;
    read_word[SPC_VIDACT_BIT]                       = video_port_enable_reg;
    read_word[SPC_STDVID_BIT]                       = !std_video_model_disable;
    read_word[SPC_VIDEN_BIT]                        = video_port_enable_reg;
    read_word[SPC_STOP_BIT]                         = card_clock_stop_policy_reg;
    read_word[SPC_MAIN_LSB +: SPC_FIELD_W]          = main_supply_request_reg;
    read_word[SPC_PROG_LSB +: SPC_FIELD_W]          = program_supply_request_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= SPC_ZERO_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_access) begin
        prdata <= hit ? read_word : SPC_ERR_READ_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && hit |-> prdata[31:12] == 20'h0_0000)
    else $error("Upper bits not zero");
  a_bit8_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite |-> !prdata[SPC_RSV8_BIT])
    else $error("Bit 8 not zero");
  a_bit3_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite |-> !prdata[SPC_RSV3_BIT])
    else $error("Bit 3 not zero");
  a_video_status: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && hit |-> prdata[SPC_VIDACT_BIT] == prdata[SPC_VIDEN_BIT])
    else $error("Video status mismatch");
  a_video_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[1] |=> video_port_enable_reg == $past(pwdata[SPC_VIDEN_BIT]))
    else $error("Video enable not stored");
  a_policy_host: assert property (@(posedge pclk) disable iff (!presetn)
    !card_clock_stop_policy_reg && !host_clock_stopping |=> !card_clock_stop_ok)
    else $error("Clock stop without host");
  a_policy_idle: assert property (@(posedge pclk) disable iff (!presetn)
    card_clock_stop_policy_reg && socket_idle |=> card_clock_stop_ok)
    else $error("Clock stop denied when idle");
  a_main_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[0] |=> main_supply_request_reg == $past(pwdata[6:4]))
    else $error("Main supply not stored");
  a_force_off: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_enabled && force_class_write |=> ##1 socket_out.main_supply == SPC_SUP_OFF)
    else $error("Supply applied while disabled");
  a_reserved_off: assert property (@(posedge pclk) disable iff (!presetn)
    main_supply_request_reg == 3'h7 |=> socket_out.main_supply == SPC_SUP_OFF)
    else $error("Reserved supply applied");

  // ----------------------------------------------------------------
  // Checks on read data and bus answer
  // ----------------------------------------------------------------
  a_std_model: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && hit |-> prdata[SPC_STDVID_BIT] != $past(std_video_model_disable))
    else $error("Model support bit wrong");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready longer than one cycle");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !hit |-> pslverr)
    else $error("Unmapped access without error");

  // ----------------------------------------------------------------
  // Checks on stored fields
  // ----------------------------------------------------------------
  a_prog_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[0] |=> program_supply_request_reg == $past(pwdata[SPC_PROG_LSB +: SPC_FIELD_W]))
    else $error("Programming supply not stored");

  a_policy_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && pstrb[0] |=> card_clock_stop_policy_reg == $past(pwdata[SPC_STOP_BIT]))
    else $error("Clock policy not stored");

  a_hold_fields: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_access |=> $stable(video_port_enable_reg) && $stable(program_supply_request_reg))
    else $error("Field changed without write");

  // ----------------------------------------------------------------
  // Checks on socket outputs and enable state
  // ----------------------------------------------------------------
  a_disabled_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_enabled |=> socket_out.main_supply == SPC_SUP_OFF && socket_out.program_supply == SPC_SUP_OFF)
    else $error("Supply granted while disabled");

  a_reint_requery: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == SPC_ST_DISABLED && card_reinterrogate_trigger |=> state_reg == SPC_ST_REQUERY)
    else $error("Re-interrogation not started");

  a_requery_enable: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == SPC_ST_REQUERY && !force_class_write |=> ctrl_enabled)
    else $error("Register not re-enabled");

  a_main_no_12v: assert property (@(posedge pclk) disable iff (!presetn)
    main_supply_request_reg == SPC_SUP_12V |=> socket_out.main_supply == SPC_SUP_OFF)
    else $error("Main supply granted reserved code");

  a_prog_12v: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_enabled && program_supply_request_reg == SPC_SUP_12V |=> socket_out.program_supply == SPC_SUP_12V)
    else $error("Programming 12 volt not granted");

  a_refused_flag: assert property (@(posedge pclk) disable iff (!presetn)
    main_refused || prog_refused |=> supply_refused)
    else $error("Refusal not flagged");

  a_video_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> socket_out.video_on == $past(video_port_enable_reg))
    else $error("Video output does not follow enable");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_video_on: cover property (@(posedge pclk) disable iff (!presetn) socket_out.video_on);
  c_clock_stop: cover property (@(posedge pclk) disable iff (!presetn) card_clock_stop_ok);
  c_disable_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == SPC_ST_DISABLED ##[1:20] state_reg == SPC_ST_ENABLED);
  c_read_ctrl: cover property (@(posedge pclk) disable iff (!presetn) pready && hit && !pwrite);
  c_refused: cover property (@(posedge pclk) disable iff (!presetn) supply_refused);

endmodule

// ### verilog/spc_supply_filter.sv
// Supply filter: passes a supply request only if enabled and the card accepts it, or it is 12 V on the programming supply.
// Assumes card class indications are synchronous to pclk and stable.
`timescale 1ns/1ns
module spc_supply_filter (
  input  wire logic [2:0]               req,
  input  wire logic                     is_prog,
  input  wire spc_pkg::spc_card_class_t card,
  input  wire logic                     enabled,
  output logic [2:0]                    grant,
  output logic                          refused
);
  import spc_pkg::*;

  // ----------------------------------------------------------------
  // Acceptance check
  // ----------------------------------------------------------------
  function automatic logic supply_ok(input logic [2:0] r, input logic p, input spc_card_class_t c);
    unique case (r)
      SPC_SUP_OFF: supply_ok = 1'b1;
      SPC_SUP_12V: supply_ok = p;
      SPC_SUP_5V:  supply_ok = c.is_5v;
      SPC_SUP_3V3: supply_ok = c.is_3v3;
      SPC_SUP_XV:  supply_ok = c.is_xv;
      SPC_SUP_YV:  supply_ok = c.is_yv;
      default:     supply_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    // Reserved or mismatched requests leave the socket unpowered
    if (enabled && supply_ok(req, is_prog, card)) begin
      grant   = req;
      refused = 1'b0;
    end else begin
      grant   = SPC_SUP_OFF;
      refused = enabled && (req != SPC_SUP_OFF);
    end
  end

endmodule
